// >>> rtl/sfar_read.sv
// Serial flash array read sequencer, device side of the serial port.
// Assumes mem_rdata follows mem_addr within one ref_clk cycle.
// Summary of operation
// - Instruction byte always enters one bit per rising serial clock edge.
// - Opcode 03h takes 3 or 4 address bytes by mode; 13h always four.
// - Opcode 0Bh takes 3 or 4 address bytes by mode; 0Ch always four.
// - Fast read inserts zero or eight dummy cycles per latency code.
// - Dual output read drives two bits per clock on two lines at fall.
// - Dual output read inserts zero or eight dummy cycles per latency.
// - Address advances after every byte and wraps to zero at the top.
// - Three-byte commands take upper address bits from the bank register.
// - Bank register four-byte bit makes 3-byte commands take four bytes.
// - Whatever the host presents during dummy cycles is ignored.
// - Dummy cycles count fall to fall; zero means data at that fall.
// - Serial outputs change on falling serial clock edges; DDR reads also change them on rising edges.
// - Dummy cycle count follows the latency code of config register one.
// - DDR commands move address and data on both edges, 1, 2 or 4 lines.
// - Quad I/O reads take mode bits deciding instruction-less follow-up.
// - Build option extends mode bits to fast DDR, dual I/O, dual DDR.
// - DDR reads drive an 8-edge learning pattern just before data.
// - Chip select rising during data ends the read.
// - Mode value Axh makes next same-type access start at the address.
// - Only the upper mode nibble counts; the lower one is ignored.
`timescale 1ns/1ps
`default_nettype none
module sfar_read
   import sfar_pkg::*;
#(
   parameter bit ENH_MODE = 1'b1
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Serial port pins
   input  wire logic              sck,
   input  wire logic              cs_n,
   input  wire logic [3:0]        io_in,
   output logic      [3:0]        io_out,
   output logic      [3:0]        io_oe,
   // Configuration
   input  wire logic [1:0]        latency_code,
   input  wire logic              lp_en,
   input  wire logic [7:0]        learning_pattern,
   // Array read port
   output logic      [MEM_AW-1:0] mem_addr,
   input  wire logic [7:0]        mem_rdata,
   // Status
   output logic      [7:0]        bank_addr,
   output logic                   four_byte_addr_en,
   output logic                   cont_active
);
   sfar_link_if lk ();

   sfar_link_sync u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .sck     (sck),
      .cs_n    (cs_n),
      .io_in   (io_in),
      .lk      (lk.src)
   );

   function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                            input logic [3:0]  io,
                                            input logic [1:0]  lw);
      case (lw)
         2'd0:    return {sr[30:0], io[0]};
         2'd1:    return {sr[29:0], io[1:0]};
         default: return {sr[27:0], io[3:0]};
      endcase
   endfunction : shift_in

   function automatic logic [3:0] line_mask(input logic [1:0] lw);
      case (lw)
         2'd0:    return 4'h2;
         2'd1:    return 4'h3;
         default: return 4'hF;
      endcase
   endfunction : line_mask

   // Output-only reads take their address on one line whatever the data width
   function automatic logic [1:0] addr_lw(input sfar_cmd_t c);
      return (c.kind == K_IO) ? c.lw : 2'd0;
   endfunction : addr_lw

   function automatic logic [5:0] addr_slots(input sfar_cmd_t c,
                                             input logic      fb);
      return ((c.wide | fb) ? ADDR4_BITS : ADDR3_BITS) >> addr_lw(c);
   endfunction : addr_slots

   sfar_state_t     st_q, st_d;
   logic [7:0]      cmd_q, cmd_d, byte_q, byte_d, bank_q, bank_d;
   logic [31:0]     sr_q, sr_d, sr_nx;
   logic [5:0]      cnt_q, cnt_d;
   logic [3:0]      bits_q, bits_d, io_out_q, io_out_d, io_oe_q, io_oe_d;
   logic [MEM_AW-1:0] mem_addr_q, mem_addr_d;
   logic            cont_q, cont_d, pend_q, pend_d, lp_q, lp_d;
   sfar_cmd_t       attr, nop;
   logic            wide4, in_edge, emit, rd_bank;
   logic [3:0]      step, mask, lp_idx;
   logic [7:0]      src;
   logic [31:0]     full_addr;

   assign attr    = sfar_decode(cmd_q, ENH_MODE);
   assign nop     = sfar_decode({sr_q[6:0], lk.io[0]}, ENH_MODE);
   assign wide4   = bank_q[BANK_4B_BIT];
   assign rd_bank = (cmd_q == OP_BANK_RD);
   assign sr_nx   = shift_in(sr_q, lk.io, addr_lw(attr));
   assign step    = 4'(4'd1 << attr.lw);
   assign mask    = line_mask(attr.lw);
   // DDR also samples the fall, but not the one before the first address bit
   assign in_edge = lk.rise | (attr.ddr & lk.fall &
                    (st_q == S_MODE || cnt_q != addr_slots(attr, wide4)));
   assign full_addr = (attr.wide | wide4) ? sr_nx :
                      {1'b0, bank_q[6:0], sr_nx[23:0]};

   always_comb begin
      st_d       = st_q;
      cmd_d      = cmd_q;
      sr_d       = sr_q;
      cnt_d      = cnt_q;
      byte_d     = byte_q;
      bits_d     = bits_q;
      bank_d     = bank_q;
      io_out_d   = io_out_q;
      io_oe_d    = io_oe_q;
      mem_addr_d = mem_addr_q;
      cont_d     = cont_q;
      pend_d     = pend_q;
      lp_d       = lp_q;
      emit       = 1'b0;
      lp_idx     = 4'h0;
      src        = byte_q;
      if (lk.cs_end) begin
         st_d    = S_IDLE;
         io_oe_d = 4'h0;
         lp_d    = 1'b0;
         // Early release leaves no trustworthy mode byte, so drop it
         cont_d  = attr.mode && pend_q &&
                   (st_q == S_DUMMY || st_q == S_DATA);
      end else if (lk.cs_start) begin
         pend_d = 1'b0;
         bits_d = 4'h0;
         if (cont_q) begin
            st_d  = S_ADDR;
            cnt_d = addr_slots(attr, wide4);
         end else begin
            st_d  = S_OPC;
            cnt_d = OPC_BITS;
         end
      end else begin
         case (st_q)
            S_OPC: if (lk.rise) begin
               sr_d  = {sr_q[30:0], lk.io[0]};
               cnt_d = cnt_q - 6'd1;
               if (cnt_q == 6'd1) begin
                  cmd_d = {sr_q[6:0], lk.io[0]};
                  if (nop.read) begin
                     st_d  = S_ADDR;
                     cnt_d = addr_slots(nop, wide4);
                  end else if (cmd_d == OP_BANK_RD) begin
                     st_d  = S_DUMMY;
                     cnt_d = 6'd0;
                  end else if (cmd_d == OP_BANK_WR) begin
                     st_d  = S_BANKW;
                     cnt_d = OPC_BITS;
                  end else begin
                     st_d = S_IGN;
                  end
               end
            end
            S_ADDR: if (in_edge) begin
               sr_d  = sr_nx;
               cnt_d = cnt_q - 6'd1;
               if (cnt_q == 6'd1) begin
                  mem_addr_d = full_addr[MEM_AW-1:0];
                  if (attr.mode) begin
                     st_d  = S_MODE;
                     cnt_d = MODE_BITS >> attr.lw;
                  end else begin
                     st_d  = S_DUMMY;
                     cnt_d = sfar_dummy(attr, latency_code);
                  end
               end
            end
            S_MODE: if (in_edge) begin
               sr_d  = sr_nx;
               cnt_d = cnt_q - 6'd1;
               if (cnt_q == 6'd1) begin
                  pend_d = (sr_nx[7:4] == MODE_CONT);
                  st_d   = S_DUMMY;
                  cnt_d  = sfar_dummy(attr, latency_code);
               end
            end
            S_DUMMY: begin
               // Host lines are never sampled here
               if (lk.fall) begin
                  if (cnt_q == 6'd0) begin
                     emit = 1'b1;
                     st_d = S_DATA;
                  end else begin
                     cnt_d = cnt_q - 6'd1;
                     if (attr.ddr && lp_en && cnt_q <= LP_CYCLES) begin
                        lp_idx   = {cnt_q[2:0], 1'b0} - 4'd1;
                        io_out_d = {4{learning_pattern[lp_idx[2:0]]}} & mask;
                        io_oe_d  = mask;
                        lp_d     = 1'b1;
                     end
                  end
               end else if (lk.rise && lp_q) begin
                  lp_idx   = {cnt_q[2:0], 1'b0};
                  io_out_d = {4{learning_pattern[lp_idx[2:0]]}} & mask;
               end
            end
            S_DATA: begin
               emit = lk.fall | (attr.ddr & lk.rise);
            end
            S_BANKW: if (lk.rise) begin
               sr_d  = {sr_q[30:0], lk.io[0]};
               cnt_d = cnt_q - 6'd1;
               if (cnt_q == 6'd1) begin
                  bank_d = {sr_q[6:0], lk.io[0]};
                  st_d   = S_IGN;
               end
            end
            default: ;
         endcase
      end
      if (emit) begin
         lp_d = 1'b0;
         if (bits_q == 4'h0) begin
            src    = rd_bank ? bank_q : mem_rdata;
            bits_d = 4'd8 - step;
            if (!rd_bank)
               mem_addr_d = mem_addr_q + MEM_AW'(1);
         end else begin
            bits_d = bits_q - step;
         end
         io_out_d = (attr.lw == 2'd0) ? {2'b00, src[7], 1'b0} :
                    (attr.lw == 2'd1) ? {2'b00, src[7:6]} : src[7:4];
         io_oe_d  = mask;
         byte_d   = src << step;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= S_IDLE;
         cmd_q      <= 8'h00;
         sr_q       <= 32'h0;
         cnt_q      <= 6'h00;
         byte_q     <= 8'h00;
         bits_q     <= 4'h0;
         bank_q     <= BANK_RST;
         io_out_q   <= 4'h0;
         io_oe_q    <= 4'h0;
         mem_addr_q <= '0;
         cont_q     <= 1'b0;
         pend_q     <= 1'b0;
         lp_q       <= 1'b0;
      end else if (ce) begin
         st_q       <= st_d;
         cmd_q      <= cmd_d;
         sr_q       <= sr_d;
         cnt_q      <= cnt_d;
         byte_q     <= byte_d;
         bits_q     <= bits_d;
         bank_q     <= bank_d;
         io_out_q   <= io_out_d;
         io_oe_q    <= io_oe_d;
         mem_addr_q <= mem_addr_d;
         cont_q     <= cont_d;
         pend_q     <= pend_d;
         lp_q       <= lp_d;
      end
   end

   assign io_out            = io_out_q;
   assign io_oe             = io_oe_q;
   assign mem_addr          = mem_addr_q;
   assign bank_addr         = bank_q;
   assign four_byte_addr_en = bank_q[BANK_4B_BIT];
   assign cont_active       = cont_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_cs_end;
      ce && lk.cs_end |=> st_q == S_IDLE && io_oe_q == 4'h0;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("read not ended");

   property p_quiet;
      ce && !lk.fall && !lk.rise && !lk.cs_end |=> $stable(io_out_q);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output moved off edge");

   property p_sdr_rise;
      ce && st_q == S_DATA && !attr.ddr && lk.rise && !lk.cs_end
         |=> $stable(io_out_q) && $stable(bits_q);
   endproperty
   a_sdr_rise: assert property (p_sdr_rise) else $error("sdr rise change");

   property p_opc;
      ce && st_q == S_OPC && lk.fall && !lk.cs_end |=> $stable(cnt_q);
   endproperty
   a_opc: assert property (p_opc) else $error("opcode on fall");

   property p_slots;
      ce && st_q == S_OPC && lk.rise && cnt_q == 6'd1 && !lk.cs_end
         && nop.read && nop.kind != K_IO
         |=> st_q == S_ADDR && cnt_q ==
             (($past(nop.wide) || bank_q[7]) ? 6'd32 : 6'd24);
   endproperty
   a_slots: assert property (p_slots) else $error("address length");

   property p_bank;
      ce && st_q == S_ADDR && in_edge && cnt_q == 6'd1 && !lk.cs_end
         && !attr.wide && !wide4
         |=> mem_addr_q[MEM_AW-1:24] == $past(bank_q[MEM_AW-25:0]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank bits lost");

   property p_first;
      ce && st_q == S_DUMMY && lk.fall && cnt_q == 6'd0 && !lk.cs_end
         |=> st_q == S_DATA && io_oe_q != 4'h0;
   endproperty
   a_first: assert property (p_first) else $error("data late");

   property p_dummy_off;
      st_q == S_DUMMY && !lp_q |-> io_oe_q == 4'h0;
   endproperty
   a_dummy_off: assert property (p_dummy_off) else $error("dummy driven");

   property p_dual;
      st_q == S_DATA && attr.kind == K_STD && attr.lw == 2'd1
         |-> io_oe_q == 4'h3;
   endproperty
   a_dual: assert property (p_dual) else $error("dual lines wrong");

   property p_step;
      ce && st_q == S_DATA && lk.fall && bits_q == 4'h0 && !rd_bank
         && !lk.cs_end |=> mem_addr_q == $past(mem_addr_q) + MEM_AW'(1);
   endproperty
   a_step: assert property (p_step) else $error("address not advanced");

   property p_cont;
      ce && lk.cs_start && cont_q |=> st_q == S_ADDR;
   endproperty
   a_cont: assert property (p_cont) else $error("no continuation");

   property p_lp;
      ce && st_q == S_DUMMY && lk.fall && cnt_q == LP_CYCLES && attr.ddr
         && lp_en && !lk.cs_end
         |=> io_out_q == ({4{$past(learning_pattern[7])}} & mask);
   endproperty
   a_lp: assert property (p_lp) else $error("pattern start wrong");

   c_data:  cover property (st_q == S_DUMMY ##1 st_q == S_DATA);
   c_cont:  cover property (lk.cs_start && cont_q);
   c_bankw: cover property (st_q == S_BANKW ##1 st_q == S_IGN);

endmodule : sfar_read
`default_nettype wire

// >>> rtl/sfar_pkg.sv
// Constants, types and decode helpers for the serial flash array read path.
// Assumes the array is byte wide and answers a read address within one clock.
package sfar_pkg;

   localparam int unsigned MEM_AW = 26;  // 64 MB array

   localparam logic [7:0] OP_READ    = 8'h03;
   localparam logic [7:0] OP_READ_W  = 8'h13;
   localparam logic [7:0] OP_FAST    = 8'h0B;
   localparam logic [7:0] OP_FAST_W  = 8'h0C;
   localparam logic [7:0] OP_DOUT    = 8'h3B;
   localparam logic [7:0] OP_DOUT_W  = 8'h3C;
   localparam logic [7:0] OP_DIO     = 8'hBB;
   localparam logic [7:0] OP_DIO_W   = 8'hBC;
   localparam logic [7:0] OP_QIO     = 8'hEB;
   localparam logic [7:0] OP_QIO_W   = 8'hEC;
   localparam logic [7:0] OP_FDDR    = 8'h0D;
   localparam logic [7:0] OP_FDDR_W  = 8'h0E;
   localparam logic [7:0] OP_DDDR    = 8'hBD;
   localparam logic [7:0] OP_DDDR_W  = 8'hBE;
   localparam logic [7:0] OP_QDDR    = 8'hED;
   localparam logic [7:0] OP_QDDR_W  = 8'hEE;
   localparam logic [7:0] OP_BANK_RD = 8'h16;
   localparam logic [7:0] OP_BANK_WR = 8'h17;

   localparam logic [7:0] BANK_RST    = 8'h00;
   localparam int unsigned BANK_4B_BIT = 7;

   localparam logic [5:0] OPC_BITS   = 6'd8;
   localparam logic [5:0] ADDR3_BITS = 6'd24;
   localparam logic [5:0] ADDR4_BITS = 6'd32;
   localparam logic [5:0] MODE_BITS  = 6'd8;
   localparam logic [3:0] MODE_CONT  = 4'hA;

   localparam logic [1:0] LC_NO_DUMMY   = 2'b11;
   localparam logic [5:0] DUMMY_STD     = 6'd8;
   localparam logic [5:0] DUMMY_IO_BASE = 6'd2;
   localparam logic [5:0] DUMMY_DDR_BASE = 6'd5;
   localparam logic [5:0] LP_CYCLES     = 6'd4;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_OPC   = 3'b001,
      S_ADDR  = 3'b010,
      S_MODE  = 3'b011,
      S_DUMMY = 3'b100,
      S_DATA  = 3'b101,
      S_BANKW = 3'b110,
      S_IGN   = 3'b111
   } sfar_state_t;

   typedef enum logic [1:0] {
      K_BASIC = 2'b00,
      K_STD   = 2'b01,
      K_IO    = 2'b10,
      K_BANK  = 2'b11
   } sfar_kind_t;

   // lw is log2 of lines per edge: 0, 1 or 2
   typedef struct packed {
      logic       read;
      logic       wide;
      logic       ddr;
      logic       mode;
      logic [1:0] lw;
      sfar_kind_t kind;
   } sfar_cmd_t;

   function automatic sfar_cmd_t sfar_decode(input logic [7:0] op,
                                             input logic       enh);
      sfar_cmd_t c;
      c = '{read: 1'b1, wide: 1'b0, ddr: 1'b0, mode: 1'b0, lw: 2'd0,
            kind: K_STD};
      case (op)
         OP_READ, OP_READ_W: c.kind = K_BASIC;
         OP_FAST, OP_FAST_W: c.kind = K_STD;
         OP_DOUT, OP_DOUT_W: c.lw = 2'd1;
         OP_DIO, OP_DIO_W: begin
            c.kind = K_IO; c.lw = 2'd1; c.mode = enh;
         end
         OP_QIO, OP_QIO_W: begin
            c.kind = K_IO; c.lw = 2'd2; c.mode = 1'b1;
         end
         OP_FDDR, OP_FDDR_W: begin
            c.kind = K_IO; c.ddr = 1'b1; c.mode = enh;
         end
         OP_DDDR, OP_DDDR_W: begin
            c.kind = K_IO; c.ddr = 1'b1; c.lw = 2'd1; c.mode = enh;
         end
         OP_QDDR, OP_QDDR_W: begin
            c.kind = K_IO; c.ddr = 1'b1; c.lw = 2'd2; c.mode = 1'b1;
         end
         default: begin
            c.read = 1'b0; c.kind = K_BANK;
         end
      endcase
      c.wide = op inside {OP_READ_W, OP_FAST_W, OP_DOUT_W, OP_DIO_W,
                          OP_QIO_W, OP_FDDR_W, OP_DDDR_W, OP_QDDR_W};
      return c;
   endfunction : sfar_decode

   function automatic logic [5:0] sfar_dummy(input sfar_cmd_t c,
                                             input logic [1:0] lc);
      logic [5:0] n;
      n = 6'd0;
      case (c.kind)
         K_STD: n = (lc == LC_NO_DUMMY) ? 6'd0 : DUMMY_STD;
         K_IO: begin
            if (c.ddr)
               n = DUMMY_DDR_BASE + {4'd0, lc};
            else if (lc != LC_NO_DUMMY)
               n = DUMMY_IO_BASE + {4'd0, lc};
         end
         default: n = 6'd0;
      endcase
      return n;
   endfunction : sfar_dummy

endpackage : sfar_pkg

// >>> rtl/sfar_link_if.sv
// Sampled serial link events passed from the pin front end to the sequencer.
// All signals are on ref_clk; pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
interface sfar_link_if;
   logic       rise;
   logic       fall;
   logic       cs_start;
   logic       cs_end;
   logic [3:0] io;
   modport src (output rise, fall, cs_start, cs_end, io);
   modport snk (input rise, fall, cs_start, cs_end, io);
endinterface : sfar_link_if
`default_nettype wire

// >>> rtl/sfar_link_sync.sv
// Pin front end: synchronises serial clock, select and data lines to ref_clk
// and reports clock edges and frame edges. Assumes ref_clk at least 8x sck.
`timescale 1ns/1ps
`default_nettype none
module sfar_link_sync
   import sfar_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Pins
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] io_in,
   // Events
   sfar_link_if.src        lk
);
   logic [5:0] s1_q, s1_d, s2_q, s2_d;
   logic [1:0] prev_q, prev_d;
   logic [3:0] io_q, io_d;
   logic       rise_q, rise_d, fall_q, fall_d;
   logic       st_q, st_d, en_q, en_d;

   always_comb begin
      s1_d   = {sck, cs_n, io_in};
      s2_d   = s1_q;
      prev_d = s2_q[5:4];
      // Data is delayed with the edges so it lines up with them
      io_d   = s2_q[3:0];
      rise_d = s2_q[5] & ~prev_q[1];
      fall_d = ~s2_q[5] & prev_q[1];
      st_d   = ~s2_q[4] & prev_q[0];
      en_d   = s2_q[4] & ~prev_q[0];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q   <= 6'h10;
         s2_q   <= 6'h10;
         prev_q <= 2'h1;
         io_q   <= 4'h0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         st_q   <= 1'b0;
         en_q   <= 1'b0;
      end else if (ce) begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         prev_q <= prev_d;
         io_q   <= io_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         st_q   <= st_d;
         en_q   <= en_d;
      end
   end

   assign lk.rise     = rise_q;
   assign lk.fall     = fall_q;
   assign lk.cs_start = st_q;
   assign lk.cs_end   = en_q;
   assign lk.io       = io_q;

endmodule : sfar_link_sync
`default_nettype wire

// >>> tb/sfar_host.sv
// Host controller model for the serial port of the flash read block.
// Assumes ref_clk at 100 ns; one serial clock lasts 8 ref_clk (800 ns).
`timescale 1ns/1ps
`default_nettype none
module sfar_host (
   // Clock
   input  wire logic       ref_clk,
   // Serial port
   output logic            sck,
   output logic            cs_n,
   output logic [3:0]      io_drv,
   output logic [3:0]      io_en,
   input  wire logic [3:0] io_wire
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io_drv = 4'h0;
      io_en = 4'h0;
   end
   task automatic start();
      @(posedge ref_clk);
      cs_n <= 1'b0;
   endtask : start
   // Data set while sck is low so it is stable at the rise; select is
   // never touched here, so it holds through mode and dummy cycles
   task automatic cyc(input logic [3:0] d, input logic [3:0] en,
                      output logic [3:0] q);
      @(posedge ref_clk);
      io_drv <= d;
      io_en <= en;
      repeat (3) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      q = io_wire;
      sck <= 1'b0;
   endtask : cyc
   // Lines go free with select so nothing is driven between frames
   task automatic stop();
      @(posedge ref_clk);
      cs_n <= 1'b1;
      io_en <= 4'h0;
      repeat (6) @(posedge ref_clk);
   endtask : stop
endmodule : sfar_host
`default_nettype wire

// >>> tb/sfar_read_tb_top.sv
// Self-checking bench for the flash read sequencer.
// Assumes the host model drives the pins; the array is a pure function.
`timescale 1ns/1ps
`default_nettype none
module sfar_read_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_n;
   logic        sck;
   logic        cs_n;
   logic        flip = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  io_in;
   logic [3:0]  io_out;
   logic [3:0]  io_oe;
   logic [3:0]  h_drv;
   logic [3:0]  h_en;
   logic [1:0]  latency_code;
   logic [25:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic [7:0]  bank_addr;
   logic        four_byte_addr_en;
   logic        cont_active;
   int          checks = 0;
   int          bad_count = 0;

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) flip <= ~flip;
   // Undriven lines toggle so a stale value cannot pass for data
   assign io_in = (io_oe & io_out) | (~io_oe & h_en & h_drv)
                | (~io_oe & ~h_en & {4{flip}});
   assign mem_rdata = pat(mem_addr);

   sfar_host u_host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n),
      .io_drv(h_drv), .io_en(h_en), .io_wire(io_in));
   // Pattern stays off, so the host owes no latency floor for it
   sfar_read u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .latency_code(latency_code), .lp_en(1'b0),
      .learning_pattern(8'hC3), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .bank_addr(bank_addr),
      .four_byte_addr_en(four_byte_addr_en), .cont_active(cont_active));

   function automatic logic [7:0] pat(input logic [25:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ {6'h0, a[25:24]} ^ 8'h5A;
   endfunction : pat
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                      input string m);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic send(input logic [31:0] v, input int n, input int w);
      logic [3:0] q;
      for (int i = n - w; i >= 0; i -= w)
         u_host.cyc(4'((v >> i) & ((32'd1 << w) - 32'd1)),
                    4'((32'd1 << w) - 32'd1), q);
   endtask : send
   // Dummy cycles: single-line host keeps junk on io0, others let go
   task automatic rd(input int skip, input int w, input logic [25:0] a);
      logic [3:0] q;
      logic [7:0] b;
      repeat (skip) u_host.cyc(4'hF, {3'h0, w == 1}, q);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 8; i += w) begin
            u_host.cyc(4'h0, 4'h0, q);
            b = (w == 1) ? {b[6:0], q[1]} :
                (w == 2) ? {b[5:0], q[1:0]} : {b[3:0], q};
         end
         chk(b, pat(a + 26'(k)), "array byte");
      end
   endtask : rd
   task automatic stop();
      u_host.stop();
      chk({4'h0, io_oe}, 8'h00, "drive after select");
   endtask : stop
   task automatic cmd(input logic [7:0] op, input int an,
                      input logic [31:0] a, input logic [25:0] ea,
                      input int skip, input int w);
      u_host.start();
      send({24'h0, op}, 8, 1);
      send(a, an, 1);
      rd(skip, w, ea);
      stop();
   endtask : cmd
   task automatic bank(input logic [7:0] v);
      u_host.start();
      send(32'h17, 8, 1);
      send({24'h0, v}, 8, 1);
      stop();
   endtask : bank
   task automatic bank_rd(input logic [7:0] e);
      logic [3:0] q;
      logic [7:0] b;
      u_host.start();
      send(32'h16, 8, 1);
      for (int i = 0; i < 8; i++) begin
         u_host.cyc(4'h0, 4'h0, q);
         b = {b[6:0], q[1]};
      end
      chk(b, e, "bank read");
      stop();
   endtask : bank_rd
   // Enhanced reads: op 00h stands for a continued frame with no opcode
   task automatic xip(input logic [7:0] op, input int w,
                      input logic [31:0] a, input logic [3:0] m);
      logic [3:0] q;
      u_host.start();
      if (op != 8'h00)
         send({24'h0, op}, 8, 1);
      send(a, 24, w);
      send({28'h0, m}, 4, w);
      // Lower mode nibble is left floating
      repeat (4 / w) u_host.cyc(4'h0, 4'h0, q);
      rd(2, w, a[25:0]);
      stop();
   endtask : xip

   initial begin
      rst_n = 1'b0;
      latency_code = 2'b11;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(bank_addr, 8'h00, "bank reset");
      chk({3'h0, cont_active, io_oe}, 8'h00, "idle outputs");
      cmd(8'h03, 24, 32'hFFFFFE, 26'h0FFFFFE, 0, 1);
      cmd(8'h13, 32, 32'h02000010, 26'h2000010, 0, 1);
      $display("test basic read done");
      for (int l = 0; l < 4; l++) begin
         @(posedge ref_clk);
         latency_code <= 2'(l);
         cmd(8'h0B, 24, 32'h100, 26'h100, l == 3 ? 0 : 8, 1);
         cmd(8'h0C, 32, 32'h1ABCDEF, 26'h1ABCDEF, l == 3 ? 0 : 8, 1);
         cmd(8'h3B, 24, 32'h0481A5, 26'h0481A5, l == 3 ? 0 : 8, 2);
         cmd(8'h3C, 32, 32'h3000F0, 26'h3000F0, l == 3 ? 0 : 8, 2);
      end
      $display("test latency done");
      @(posedge ref_clk);
      latency_code <= 2'b00;
      xip(8'hBB, 2, 32'h00A0F1, 4'hA);
      chk({7'h0, cont_active}, 8'h01, "continuation armed");
      xip(8'h00, 2, 32'h00A100, 4'h5);
      chk({7'h0, cont_active}, 8'h00, "continuation ended");
      xip(8'hEB, 4, 32'h7F0E03, 4'hA);
      chk({7'h0, cont_active}, 8'h01, "quad continuation");
      xip(8'h00, 4, 32'h123455, 4'h0);
      chk({7'h0, cont_active}, 8'h00, "quad released");
      @(posedge ref_clk);
      latency_code <= 2'b11;
      $display("test continuation done");
      bank(8'h01);
      chk(bank_addr, 8'h01, "bank value");
      // A frame sent while the block is frozen must leave no trace
      @(posedge ref_clk);
      ce <= 1'b0;
      bank(8'h55);
      chk(bank_addr, 8'h01, "frozen bank");
      @(posedge ref_clk);
      ce <= 1'b1;
      bank_rd(8'h01);
      cmd(8'h03, 24, 32'h123456, 26'h1123456, 0, 1);
      bank(8'h80);
      chk({7'h0, four_byte_addr_en}, 8'h01, "four byte mode");
      cmd(8'h03, 32, 32'h03FFFFFF, 26'h3FFFFFF, 0, 1);
      cmd(8'h0B, 32, 32'h200, 26'h200, 0, 1);
      $display("test bank done");
      results();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      results();
   end
endmodule : sfar_read_tb_top
`default_nettype wire
